// file: gci_status_config_registers.sv
`timescale 1ns/1ps
module gci_status_config_registers
  import cfg_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mon_valid,
  input wire logic [7:0] mon_byte,
  input wire logic [1:0] mon_ch,
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire logic ref2048_en,
  input wire logic clock_unsync,
  input wire logic input_mux_strobe,
  input wire logic [NCH-1:0] debounced_input_one,
  input wire logic [NCH-1:0] debounced_input_two,
  input wire logic [NCH-1:0] multiplexed_input_bit,
  input wire logic [NCH*7-1:0] pins_in,
  input wire logic ci_down_valid,
  input wire logic [1:0] ci_down_ch,
  input wire logic [4:0] ci_down_bits,
  output logic [NCH*5-1:0] pins_out,
  output logic [NCH*5-1:0] pins_oe,
  output logic [NCH*3-1:0] ci_up_bits,
  output logic [NCH-1:0] tx_path_cut,
  output logic [NCH-1:0] rx_path_cut,
  output logic [NCH-1:0] balance_filter_off,
  output logic [NCH-1:0] highpass_bypass,
  output logic [NCH-1:0] reduced_rx_gain,
  output logic [NCH-1:0] arm_tx_interrupt,
  output logic [NCH-1:0] interface_loopback,
  output logic [NCH-1:0] full_digital_loopback,
  output logic [NCH-1:0] rx_test_tone,
  output logic [NCH-1:0] mu_law_sel,
  output logic [NCH*6-1:0] coef_sel,
  output logic [NCH-1:0] channel_active_flag,
  output logic [NCH-1:0] analog_out_hiz,
  output logic interrupt_output_type,
  output logic chopper_rate_select,
  output logic chopper_clk_en,
  output logic inactive_output_mode
);
  // elaboration check: storage and pin maps are laid out for four channels
  if (NCH != 4) begin : gen_bad_nch
    $error("block serves exactly four channels");
  end
  // ==========================================================
  // pin synchronisers
  logic [NCH*7-1:0] pins_s1_reg;
  logic [NCH*7-1:0] pins_s2_reg;
  logic [NCH-1:0] dbi1_s1_reg, dbi1_s2_reg;
  logic [NCH-1:0] dbi2_s1_reg, dbi2_s2_reg;
  logic [NCH-1:0] mux_s1_reg, mux_s2_reg;
  logic clock_fail_flag_s1_reg, clock_fail_flag_s2_reg;
  logic strobe_s1_reg, strobe_s2_reg;
  // pin levels, two stages before any logic reads them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
    end else begin
      pins_s1_reg <= pins_in;
      pins_s2_reg <= pins_s1_reg;
    end
  end
  // debounced input one, two stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbi1_s1_reg <= '0;
      dbi1_s2_reg <= '0;
    end else begin
      dbi1_s1_reg <= debounced_input_one;
      dbi1_s2_reg <= dbi1_s1_reg;
    end
  end
  // debounced input two, two stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbi2_s1_reg <= '0;
      dbi2_s2_reg <= '0;
    end else begin
      dbi2_s1_reg <= debounced_input_two;
      dbi2_s2_reg <= dbi2_s1_reg;
    end
  end
  // multiplexed input bits, two stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mux_s1_reg <= '0;
      mux_s2_reg <= '0;
    end else begin
      mux_s1_reg <= multiplexed_input_bit;
      mux_s2_reg <= mux_s1_reg;
    end
  end
  // clock fail status; only the second stage reads the first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clock_fail_flag_s1_reg <= 1'b0;
      clock_fail_flag_s2_reg <= 1'b0;
    end else begin
      clock_fail_flag_s1_reg <= clock_unsync;
      clock_fail_flag_s2_reg <= clock_fail_flag_s1_reg;
    end
  end
  // input mux strobe, two stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
    end else begin
      strobe_s1_reg <= input_mux_strobe;
      strobe_s2_reg <= strobe_s1_reg;
    end
  end
  // ==========================================================
  // per-channel storage
  chan_if cbus();
  logic [NCH*8-1:0] opcond_all;
  logic [NCH*7-1:0] opfunc_all;
  logic [NCH*5-1:0] pindir_all;
  chan_regs #(.NCH(NCH)) u_chan (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(cbus),
    .opcond_all(opcond_all),
    .opfunc_all(opfunc_all),
    .pindir_all(pindir_all)
  );
  // ==========================================================
  // global registers and sequencer
  seq_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [1:0] ch_reg;
  logic [1:0] chipcfg_reg;
  logic [7:0] opmode_reg;
  logic [NCH-1:0] active_reg;
  logic cmd_wr, cmd_rd;
  logic [6:0] cmd_hi;
  assign cmd_hi = mon_byte[7:1];
  // decode of a command byte: upper seven bits pick register
  always_comb begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    if (cmd_hi == CMD_OPCOND || cmd_hi == CMD_CHIPCFG || cmd_hi == CMD_OPFUNC ||
        cmd_hi == CMD_PINDIR || cmd_hi == CMD_OPMODE) begin
      cmd_wr = ~mon_byte[0];
      cmd_rd = mon_byte[0];
    end else if (mon_byte == {CMD_PINSET, 1'b0}) begin
      cmd_wr = 1'b1;
      // 53h shares its upper bits with 52h, so it is matched whole
    end else if (mon_byte == CMD_PINSTATE_RD) begin
      cmd_rd = 1'b1;
    end
  end
  // data byte of a write command
  logic data_phase;
  assign data_phase = (state_reg == ST_DATA) && mon_valid;
  // command byte and its channel, captured in the idle state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_reg <= 8'h00;
      ch_reg <= 2'h0;
    end else if (state_reg == ST_CMD && mon_valid) begin
      cmd_reg <= mon_byte;
      ch_reg <= mon_ch;
    end
  end
  // sequencer: command byte, then data byte or reply
  // bytes arriving in the reply cycle are dropped, so a read needs idle room
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_CMD;
    end else begin
      case (state_reg)
        ST_CMD: begin
          if (mon_valid && cmd_wr) begin
            state_reg <= ST_DATA;
          end else if (mon_valid && cmd_rd) begin
            state_reg <= ST_REPLY;
          end
        end
        ST_DATA: if (mon_valid) state_reg <= ST_CMD;
        ST_REPLY: state_reg <= ST_CMD;
        default: state_reg <= ST_CMD;
      endcase
    end
  end
  // channel bus towards per-channel storage
  always_comb begin
    cbus.ch = (state_reg == ST_CMD) ? mon_ch : ch_reg;
    cbus.wdata = mon_byte;
    cbus.wr_opcond = data_phase && cmd_reg[7:1] == CMD_OPCOND;
    cbus.wr_opfunc = data_phase && cmd_reg[7:1] == CMD_OPFUNC;
    cbus.wr_pindir = data_phase && cmd_reg[7:1] == CMD_PINDIR;
  end
  // single shared chip configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chipcfg_reg <= CHIPCFG_RST;
    end else if (data_phase && cmd_reg[7:1] == CMD_CHIPCFG) begin
      chipcfg_reg <= mon_byte[7:6];
    end
  end
  // single shared operating mode
  // all eight bits kept; the low-power bit drives nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opmode_reg <= OPMODE_RST;
    end else if (data_phase && cmd_reg[7:1] == CMD_OPMODE) begin
      opmode_reg <= mon_byte;
    end
  end
  // channel activity from activate/deactivate commands
  // these commands carry no data byte, so they act in the idle state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_reg <= '0;
    end else if (state_reg == ST_CMD && mon_valid) begin
      if (mon_byte == CMD_ACTIVATE) active_reg[mon_ch] <= 1'b1;
      else if (mon_byte == CMD_DEACTIVATE) active_reg[mon_ch] <= 1'b0;
    end
  end
  // ==========================================================
  // output pin latches: downstream C/I, or 52h write
  // a C/I field in the same cycle as a 52h data byte wins
  logic [NCH*5-1:0] pin_drive_reg;
  logic pinset_wr;
  assign pinset_wr = data_phase && cmd_reg == {CMD_PINSET, 1'b0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_drive_reg <= '0;
    end else if (ci_down_valid) begin
      pin_drive_reg[ci_down_ch*5 +: 5] <= ci_down_bits;
    end else if (pinset_wr) begin
      pin_drive_reg[ch_reg*5 +: 5] <= {mon_byte[4:2], mon_byte[1:0]};
    end
  end
  // ==========================================================
  // read reply, one cycle after the storage read settles
  logic [4:0] pin_lvl;
  logic [6:0] raw;
  always_comb begin
    raw = pins_s2_reg[ch_reg*7 +: 7];
    pin_lvl = raw[4:0];
  end
  // reply register; reserved bits read back as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reply_valid <= 1'b0;
      reply_byte <= 8'h00;
    end else begin
      reply_valid <= 1'b0;
      if (state_reg == ST_REPLY) begin
        reply_valid <= 1'b1;
        case (cmd_reg[7:1])
          CMD_OPCOND: reply_byte <= cbus.opcond;
          CMD_CHIPCFG: reply_byte <= {chipcfg_reg, 6'h00};
          CMD_OPFUNC: reply_byte <= {1'b0, cbus.opfunc};
          CMD_PINDIR: reply_byte <= {1'b0, active_reg[ch_reg], clock_fail_flag_s2_reg,
                                      cbus.pindir};
          CMD_OPMODE: reply_byte <= opmode_reg;
          default: reply_byte <= {raw[6], raw[5], mux_s2_reg[ch_reg], pin_lvl[4:2],
                                   pin_lvl[1], pin_lvl[0]};
        endcase
      end
    end
  end
  // ==========================================================
  // per-channel decode of control bits
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : gen_out
      logic [7:0] oc;
      logic [4:0] dir;
      logic ci_one, ci_two, ci_c3;
      assign oc = opcond_all[c*8 +: 8];
      assign dir = pindir_all[c*5 +: 5];
      assign tx_path_cut[c] = oc[OC_TX_CUT];
      assign rx_path_cut[c] = oc[OC_RX_CUT];
      // receive cutoff also silences the balance filter
      assign balance_filter_off[c] = oc[OC_RX_CUT];
      assign highpass_bypass[c] = oc[OC_HPF_BYP];
      assign reduced_rx_gain[c] = oc[OC_RGAIN];
      assign arm_tx_interrupt[c] = oc[OC_ARM_TX];
      assign interface_loopback[c] = oc[OC_ILB];
      assign full_digital_loopback[c] = oc[OC_FDL];
      assign rx_test_tone[c] = oc[OC_TONE];
      assign mu_law_sel[c] = opfunc_all[c*7 + OF_LAW];
      assign coef_sel[c*6 +: 6] = opfunc_all[c*7 +: 6];
      assign channel_active_flag[c] = active_reg[c];
      assign analog_out_hiz[c] = ~active_reg[c] & opmode_reg[OM_INACTIVE_OUTPUT_MODE];
      // drive always present; the enable follows the direction bit
      assign pins_out[c*5 +: 5] = pin_drive_reg[c*5 +: 5];
      assign pins_oe[c*5 +: 5] = dir;
      // upstream C/I, forced low where the pin is an output
      assign ci_one = dir[0] ? 1'b0 : dbi1_s2_reg[c];
      // second slot carries the mux bit while the synced strobe is high
      assign ci_two = dir[1] ? 1'b0 : (strobe_s2_reg ? mux_s2_reg[c] : dbi2_s2_reg[c]);
      assign ci_c3 = dir[2] ? 1'b0 : pins_s2_reg[c*7 + 2];
      assign ci_up_bits[c*3 +: 3] = {ci_c3, ci_two, ci_one};
    end
  endgenerate
  // global configuration outputs
  assign interrupt_output_type = chipcfg_reg[1];
  assign chopper_rate_select = chipcfg_reg[0];
  assign inactive_output_mode = opmode_reg[OM_INACTIVE_OUTPUT_MODE];
  // chopper clock enable
  chopper_div u_chop (
    .ref_clk(ref_clk),
    .rst(rst),
    .ref_en(ref2048_en),
    .rate_sel(chipcfg_reg[0]),
    .chop_en(chopper_clk_en)
  );
endmodule

// file: cfg_pkg.sv
package cfg_pkg;
  // ==========================================================
  // command bytes (bit 0 is the write/read select)
  localparam logic [6:0] CMD_OPCOND = 7'h38;
  localparam logic [6:0] CMD_CHIPCFG = 7'h23;
  localparam logic [6:0] CMD_OPFUNC = 7'h30;
  localparam logic [6:0] CMD_PINDIR = 7'h2A;
  localparam logic [6:0] CMD_OPMODE = 7'h25;
  localparam logic [6:0] CMD_PINSET = 7'h29;
  localparam logic [7:0] CMD_PINSTATE_RD = 8'h53;
  localparam logic [7:0] CMD_DEACTIVATE = 8'h00;
  localparam logic [7:0] CMD_ACTIVATE = 8'h0E;
  // ==========================================================
  // reset values
  localparam logic [7:0] OPCOND_RST = 8'h00;
  localparam logic [1:0] CHIPCFG_RST = 2'h0;
  localparam logic [6:0] OPFUNC_RST = 7'h00;
  localparam logic [4:0] PINDIR_RST = 5'h00;
  localparam logic [7:0] OPMODE_RST = 8'h0F;
  // ==========================================================
  // field positions
  localparam int OC_TX_CUT = 7;
  localparam int OC_RX_CUT = 6;
  localparam int OC_HPF_BYP = 5;
  localparam int OC_RGAIN = 4;
  localparam int OC_ARM_TX = 3;
  localparam int OC_ILB = 2;
  localparam int OC_FDL = 1;
  localparam int OC_TONE = 0;
  localparam int CC_INT_TYPE = 7;
  localparam int CC_CHOP = 6;
  localparam int OF_LAW = 6;
  localparam int PD_ACTIVE = 6;
  localparam int PD_CLOCK_FAIL_FLAG = 5;
  localparam int OM_INACTIVE_OUTPUT_MODE = 5;
  // chopper divide ratios of the 2048 kHz reference
  localparam logic [3:0] CHOP_DIV_SLOW = 4'h8;
  localparam logic [3:0] CHOP_DIV_FAST = 4'h7;
  // command sequencer states
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_DATA = 3'b010,
    ST_REPLY = 3'b100
  } seq_state_t;
endpackage

// file: chan_if.sv
`timescale 1ns/1ps
// per-channel register access between sequencer and storage
interface chan_if;
  logic [1:0] ch;
  logic [7:0] opcond;
  logic [6:0] opfunc;
  logic [4:0] pindir;
  logic wr_opcond;
  logic wr_opfunc;
  logic wr_pindir;
  logic [7:0] wdata;
  modport store (input ch, wr_opcond, wr_opfunc, wr_pindir, wdata,
    output opcond, opfunc, pindir);
  modport user (output ch, wr_opcond, wr_opfunc, wr_pindir, wdata,
    input opcond, opfunc, pindir);
endinterface

// file: chan_regs.sv
`timescale 1ns/1ps
// per-channel copies of non-global bits, registered read data
module chan_regs
  import cfg_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  chan_if.store bus,
  output logic [NCH*8-1:0] opcond_all,
  output logic [NCH*7-1:0] opfunc_all,
  output logic [NCH*5-1:0] pindir_all
);
  if (NCH != 4) begin : gen_bad_nch
    $error("chan_regs serves four channels");
  end
  // ==========================================================
  // storage, one generate entry per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      logic [7:0] oc_reg;
      logic [6:0] of_reg;
      logic [4:0] pd_reg;
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          oc_reg <= OPCOND_RST;
          of_reg <= OPFUNC_RST;
          pd_reg <= PINDIR_RST;
        end else if (bus.ch == 2'(g)) begin
          if (bus.wr_opcond) oc_reg <= bus.wdata;
          if (bus.wr_opfunc) of_reg <= bus.wdata[6:0];
          if (bus.wr_pindir) pd_reg <= bus.wdata[4:0];
        end
      end
      assign opcond_all[g*8 +: 8] = oc_reg;
      assign opfunc_all[g*7 +: 7] = of_reg;
      assign pindir_all[g*5 +: 5] = pd_reg;
    end
  endgenerate
  // registered read of the addressed channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus.opcond <= OPCOND_RST;
      bus.opfunc <= OPFUNC_RST;
      bus.pindir <= PINDIR_RST;
    end else begin
      bus.opcond <= opcond_all[bus.ch*8 +: 8];
      bus.opfunc <= opfunc_all[bus.ch*7 +: 7];
      bus.pindir <= pindir_all[bus.ch*5 +: 5];
    end
  end
endmodule

// file: chopper_div.sv
`timescale 1ns/1ps
// divides the 2048 kHz reference enable by 8 or 7
module chopper_div
  import cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ref_en,
  input wire logic rate_sel,
  output logic chop_en
);
  logic [3:0] cnt_reg;
  logic [3:0] div;
  assign div = rate_sel ? CHOP_DIV_FAST : CHOP_DIV_SLOW;
  // count reference ticks, pulse on wrap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      chop_en <= 1'b0;
    end else begin
      chop_en <= 1'b0;
      if (ref_en) begin
        if (cnt_reg >= div - 4'h1) begin
          cnt_reg <= 4'h0;
          chop_en <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

// file: gci_cfg_props.sv
`timescale 1ns/1ps
// ====
// monitor channel and register output checks
module gci_cfg_props
  import cfg_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mon_valid,
  input wire logic [7:0] mon_byte,
  input wire logic [1:0] mon_ch,
  input wire logic reply_valid,
  input wire logic [NCH-1:0] tx_path_cut,
  input wire logic [NCH-1:0] rx_path_cut,
  input wire logic [NCH-1:0] balance_filter_off,
  input wire logic [NCH-1:0] highpass_bypass,
  input wire logic [NCH-1:0] reduced_rx_gain,
  input wire logic [NCH-1:0] arm_tx_interrupt,
  input wire logic [NCH-1:0] interface_loopback,
  input wire logic [NCH-1:0] full_digital_loopback,
  input wire logic [NCH-1:0] rx_test_tone,
  input wire logic [NCH-1:0] mu_law_sel,
  input wire logic [NCH*6-1:0] coef_sel,
  input wire logic [NCH*5-1:0] pins_oe,
  input wire logic [NCH-1:0] channel_active_flag,
  input wire logic interrupt_output_type,
  input wire logic chopper_rate_select
);
  logic dph_reg;
  logic [7:0] cmd_reg;
  logic [1:0] ch_reg;
  // next monitor byte is data after a write command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dph_reg <= 1'b0;
    end else if (mon_valid) begin
      dph_reg <= !dph_reg && !mon_byte[0] && mon_byte[7:4] != 4'h0;
    end
  end
  // command and channel of the current transfer
  always_ff @(posedge ref_clk) begin
    if (mon_valid && !dph_reg) begin
      cmd_reg <= mon_byte;
      ch_reg <= mon_ch;
    end
  end
  // addressed channel's operating-condition outputs
  wire logic [7:0] oc_bits = {tx_path_cut[ch_reg], rx_path_cut[ch_reg], highpass_bypass[ch_reg],
    reduced_rx_gain[ch_reg], arm_tx_interrupt[ch_reg], interface_loopback[ch_reg],
    full_digital_loopback[ch_reg], rx_test_tone[ch_reg]};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // command byte and data byte of one transfer
  sequence s_cmd(logic [7:0] c);
    mon_valid && !dph_reg && mon_byte == c;
  endsequence
  sequence s_data(logic [7:0] c);
    mon_valid && dph_reg && cmd_reg == c;
  endsequence
  AST_RD_REPLY: assert property (s_cmd(8'h71) |=> !reply_valid ##1 reply_valid)
    else $error("read reply not two edges after command");
  AST_RPL_PULSE: assert property (reply_valid |=> !reply_valid)
    else $error("reply valid longer than one cycle");
  AST_OC_WR: assert property (s_data(8'h70) |=> oc_bits == $past(mon_byte))
    else $error("operating conditions outputs differ from written byte");
  AST_BFILT: assert property (balance_filter_off == rx_path_cut)
    else $error("balance filter not off with receive cutoff");
  AST_OF_WR: assert property (s_data(8'h60) |=>
    {mu_law_sel[ch_reg], coef_sel[ch_reg*6 +: 6]} == $past(mon_byte[6:0]))
    else $error("law or coefficient select differs from written byte");
  AST_DIR_WR: assert property (s_data(8'h54) |=> pins_oe[ch_reg*5 +: 5] == $past(mon_byte[4:0]))
    else $error("pin enables differ from written direction");
  AST_CC_WR: assert property (s_data(8'h46) |=>
    {interrupt_output_type, chopper_rate_select} == $past(mon_byte[7:6]))
    else $error("global chip configuration differs from written byte");
  AST_ACT: assert property (s_cmd(CMD_ACTIVATE) |=> ##[0:1] channel_active_flag[ch_reg])
    else $error("channel not active after activate");
  AST_DEACT: assert property (s_cmd(CMD_DEACTIVATE) |=> ##[0:1] !channel_active_flag[ch_reg])
    else $error("channel still active after deactivate");
endmodule

bind gci_status_config_registers gci_cfg_props #(.NCH(NCH)) u_props (
  .ref_clk, .rst, .mon_valid, .mon_byte, .mon_ch, .reply_valid, .tx_path_cut, .rx_path_cut,
  .balance_filter_off, .highpass_bypass, .reduced_rx_gain, .arm_tx_interrupt,
  .interface_loopback, .full_digital_loopback, .rx_test_tone, .mu_law_sel, .coef_sel,
  .pins_oe, .channel_active_flag, .interrupt_output_type, .chopper_rate_select
);

// file: gci_ctrl_model.sv
`timescale 1ns/1ps
// ====
// upstream controller on the monitor channel
module gci_ctrl_model (
  output logic mon_valid,
  output logic [7:0] mon_byte,
  output logic [1:0] mon_ch,
  input wire logic ref_clk,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte
);
  int gap = 0; // idle cycles before each byte, for a slow controller
  // idle lines at time zero
  initial begin
    mon_valid = 1'b0;
    mon_byte = 8'h00;
    mon_ch = 2'h0;
  end
  // one byte held for one edge, then released with inverted lines
  task automatic put(input logic [1:0] ch, input logic [7:0] b);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    mon_valid <= 1'b1;
    mon_byte <= b;
    mon_ch <= ch;
    @(posedge ref_clk);
    mon_valid <= 1'b0;
    mon_byte <= ~b;
    mon_ch <= ~ch;
  endtask
  // write: command with bit 0 clear, then one data byte
  task automatic wr(input logic [1:0] ch, input logic [7:0] cmd, input logic [7:0] d);
    put(ch, cmd);
    put(ch, d);
  endtask
  // read: command with bit 0 set, reply taken under a bounded wait
  task automatic rd(input logic [1:0] ch, input logic [7:0] cmd, output logic [7:0] d);
    put(ch, cmd);
    d = 8'hEE;
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      if (reply_valid === 1'b1) begin
        d = reply_byte;
        break;
      end
    end
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
// ====
// self-checking bench for the configuration register bank
module tb;
  import cfg_pkg::*;
  logic ref_clk, rst, mon_valid, reply_valid, clock_unsync;
  logic ref2048_en = 1'b0;
  logic input_mux_strobe, ci_down_valid, chopper_clk_en, inactive_output_mode;
  logic [7:0] mon_byte, reply_byte;
  logic [1:0] mon_ch, ci_down_ch;
  logic [3:0] debounced_input_one, debounced_input_two, multiplexed_input_bit, analog_out_hiz;
  logic [27:0] pins_in;
  logic [4:0] ci_down_bits;
  logic [19:0] pins_out, pins_oe;
  logic [11:0] ci_up_bits;
  int errors = 0;
  int tests_run = 0;
  int tick = 0;
  // design and upstream controller
  gci_status_config_registers #(.NCH(4)) i_gci_status_config_registers (
    .ref_clk, .rst, .mon_valid, .mon_byte, .mon_ch, .reply_valid, .reply_byte, .ref2048_en,
    .clock_unsync, .input_mux_strobe, .debounced_input_one, .debounced_input_two,
    .multiplexed_input_bit, .pins_in, .ci_down_valid, .ci_down_ch, .ci_down_bits, .pins_out,
    .pins_oe, .ci_up_bits, .tx_path_cut(), .rx_path_cut(), .balance_filter_off(),
    .highpass_bypass(), .reduced_rx_gain(), .arm_tx_interrupt(), .interface_loopback(),
    .full_digital_loopback(), .rx_test_tone(), .mu_law_sel(), .coef_sel(),
    .channel_active_flag(), .analog_out_hiz, .interrupt_output_type(),
    .chopper_rate_select(), .chopper_clk_en, .inactive_output_mode
  );
  gci_ctrl_model i_gci_ctrl_model (
    .ref_clk, .mon_valid, .mon_byte, .mon_ch, .reply_valid, .reply_byte
  );
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // reference tick every 20 cycles
  always @(posedge ref_clk) begin
    tick <= (tick == 19) ? 0 : tick + 1;
    ref2048_en <= (tick == 19);
  end
  // ====
  // shared tasks
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [1:0] ch, input logic [7:0] cmd, input logic [7:0] d);
    i_gci_ctrl_model.wr(ch, cmd, d);
  endtask
  task automatic rdc(input logic [1:0] ch, input logic [7:0] cmd, input logic [7:0] e);
    logic [7:0] d;
    i_gci_ctrl_model.rd(ch, cmd, d);
    chk(e, d);
  endtask
  task automatic cidn(input logic [4:0] b);
    @(posedge ref_clk);
    ci_down_ch <= 2'h2;
    ci_down_bits <= b;
    ci_down_valid <= 1'b1;
    @(posedge ref_clk);
    ci_down_valid <= 1'b0;
    settle();
  endtask
  // reference ticks between chopper pulses; two intervals discarded
  task automatic count_chop(input logic [7:0] n);
    logic [7:0] c;
    for (int p = 0; p < 3; p++) begin
      c = 8'h00;
      for (int k = 0; k < 400; k++) begin
        @(posedge ref_clk);
        c = c + 8'(ref2048_en);
        if (chopper_clk_en === 1'b1) break;
      end
    end
    chk(n, c);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    rdc(2'h0, 8'h71, 8'h00);
    rdc(2'h0, 8'h47, 8'h00);
    rdc(2'h0, 8'h61, 8'h00);
    rdc(2'h0, 8'h55, 8'h00);
    rdc(2'h0, 8'h4B, 8'h0F);
    chk(8'h00, inactive_output_mode);
    $display("test reset values done");
  endtask
  task automatic t_regs;
    logic [7:0] v [4] = '{8'hC1, 8'h24, 8'h5A, 8'h96};
    for (int i = 0; i < 4; i++) begin
      wr(2'(i), 8'h70, v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rdc(2'(i), 8'h71, v[i]);
    end
    i_gci_ctrl_model.gap = 3;
    wr(2'h3, 8'h60, 8'h7F);
    i_gci_ctrl_model.gap = 0;
    rdc(2'h3, 8'h61, 8'h7F);
    rdc(2'h0, 8'h61, 8'h00);
    $display("test channel registers done");
  endtask
  task automatic t_pins;
    clock_unsync <= 1'b1;
    pins_in <= 28'h0012B00;
    debounced_input_one <= 4'h6;
    multiplexed_input_bit <= 4'h2;
    wr(2'h2, 8'h54, 8'h1F);
    settle();
    chk(8'h1F, pins_oe[14:10]);
    rdc(2'h2, 8'h55, 8'h3F);
    rdc(2'h0, 8'h55, 8'h20);
    rdc(2'h1, 8'h53, 8'hB6);
    chk(8'h05, ci_up_bits[5:3]);
    chk(8'h00, ci_up_bits[8:6]);
    input_mux_strobe <= 1'b1;
    settle();
    chk(8'h07, ci_up_bits[5:3]);
    i_gci_ctrl_model.put(2'h2, CMD_ACTIVATE);
    rdc(2'h2, 8'h55, 8'h7F);
    i_gci_ctrl_model.put(2'h2, CMD_DEACTIVATE);
    rdc(2'h2, 8'h55, 8'h3F);
    cidn(5'h15);
    chk(8'h15, pins_out[14:10]);
    wr(2'h2, 8'h52, 8'h0A);
    settle();
    chk(8'h0A, pins_out[14:10]);
    cidn(5'h11);
    chk(8'h11, pins_out[14:10]);
    clock_unsync <= 1'b0;
    $display("test line pins done");
  endtask
  task automatic t_chop;
    count_chop(8'h08);
    wr(2'h0, 8'h46, 8'hC0);
    rdc(2'h1, 8'h47, 8'hC0);
    count_chop(8'h07);
    $display("test chopper done");
  endtask
  task automatic t_mode;
    wr(2'h0, 8'h4A, 8'h20);
    rdc(2'h1, 8'h4B, 8'h20);
    settle();
    chk(8'h0F, analog_out_hiz);
    chk(8'h01, inactive_output_mode);
    i_gci_ctrl_model.put(2'h0, CMD_ACTIVATE);
    settle();
    chk(8'h0E, analog_out_hiz);
    $display("test operating mode done");
  endtask
  // ====
  // main sequence
  initial begin
    rst = 1'b1;
    clock_unsync = 1'b0;
    input_mux_strobe = 1'b0;
    ci_down_valid = 1'b0;
    ci_down_ch = 2'h0;
    ci_down_bits = 5'h00;
    debounced_input_one = 4'h0;
    debounced_input_two = 4'h0;
    multiplexed_input_bit = 4'h0;
    pins_in = 28'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_pins();
    t_chop();
    t_mode();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
